/* pkg/pump_ctrl_consts.svh */
`ifndef PUMP_CTRL_CONSTS_SVH
`define PUMP_CTRL_CONSTS_SVH
`define CLK_MHZ 100
`define OFF_LOW_TIME_US 1500
`define OFF_LOW_CYC (`OFF_LOW_TIME_US * `CLK_MHZ)
`define PWRDN_DELAY_US 1000
`define PWRDN_DELAY_CYC (`PWRDN_DELAY_US * `CLK_MHZ)
`define GAIN1_DELAY_US 120
`define GAIN1_DELAY_CYC (`GAIN1_DELAY_US * `CLK_MHZ)
`define GAIN2_DELAY_US 400
`define GAIN2_DELAY_CYC (`GAIN2_DELAY_US * `CLK_MHZ)
`define STEP_MA 2
`define CODE_W 4
`define CODE_ZERO 4'h0
`define CODE_ONE 4'h1
`define NUM_CH 6
`define CNT_W 20
`define CNT_ZERO 20'h00000
`define CNT_ONE 20'h00001
`define CNT_PAD 12'h000
`define LIM_ONE 32'h00000001
`define GAIN_SKIP_CYC 1
`define CH_NONE 6'h00
`define GAIN_1X 2'h0
`define GAIN_133X 2'h1
`define GAIN_15X 2'h3
`define GAIN_2X 2'h2
`endif

/* pkg/pump_ctrl_pkg.sv */
package pump_ctrl_pkg;
  typedef enum logic [1:0] {
    GAIN_ST_1X = 2'h0,
    GAIN_ST_133X = 2'h1,
    GAIN_ST_15X = 2'h3,
    GAIN_ST_2X = 2'h2
  } gain_e;
  typedef enum logic [1:0] {
    EN_ST_OFF = 2'h0,
    EN_ST_ON = 2'h1,
    EN_ST_LOWWAIT = 2'h3,
    EN_ST_PWRDN = 2'h2
  } en_e;
  typedef logic [3:0] code_t;
  typedef logic [19:0] cnt_t;
endpackage : pump_ctrl_pkg

/* core/pin_sync3.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pump_ctrl_consts.svh"
// ----------------------------------------
// three-stage pin synchroniser
// ----------------------------------------
module pin_sync3 (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level
);
  import pump_ctrl_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_s;
  sync_s st_reg;
  sync_s st_next;
  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // only accept once stages two and three agree
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_level = st_reg.lvl;
endmodule : pin_sync3
`default_nettype wire

/* core/pulse_dimming_pump_mode_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pump_ctrl_consts.svh"
module pulse_dimming_pump_mode_ctrl #(
  parameter int unsigned OFF_LOW_CYC = `OFF_LOW_CYC,
  parameter int unsigned PWRDN_DELAY_CYC = `PWRDN_DELAY_CYC,
  parameter int unsigned GAIN1_DELAY_CYC = `GAIN1_DELAY_CYC,
  parameter int unsigned GAIN2_DELAY_CYC = `GAIN2_DELAY_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_enable_program,
  input wire logic i_supply_undervoltage,
  input wire logic i_regulation_low,
  input wire logic i_onex_sufficient,
  input wire logic [5:0] i_cathode_near_output,
  output logic o_device_enabled,
  output logic [3:0] o_current_code,
  output logic [5:0] o_channel_on,
  output logic [5:0] o_test_current_on,
  output pump_ctrl_pkg::gain_e o_gain_mode
);
  import pump_ctrl_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    en_e en_st;
    logic pin_d;
    code_t code;
    cnt_t low_cnt;
    cnt_t gain_cnt;
    gain_e gain;
    logic enabled;
    logic [5:0] ch_on;
    logic [5:0] test_on;
  } ctrl_s;

  ctrl_s st_reg;
  ctrl_s st_next;
  logic pin_lvl;

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  pin_sync3 u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin(i_enable_program),
    .o_level(pin_lvl)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic cnt_hit(input cnt_t cnt, input int unsigned lim);
    cnt_hit = ({`CNT_PAD, cnt} >= (lim - `LIM_ONE));
  endfunction : cnt_hit

  function automatic cnt_t cnt_inc(input cnt_t cnt);
    cnt_inc = cnt + `CNT_ONE;
  endfunction : cnt_inc

  function automatic logic is_on(input en_e st);
    is_on = (st == EN_ST_ON);
  endfunction : is_on

  // ladder only climbs; the way down is always straight to 1x
  function automatic gain_e gain_up(input gain_e g);
    case (g)
      GAIN_ST_1X: begin
        gain_up = GAIN_ST_133X;
      end
      GAIN_ST_133X: begin
        gain_up = GAIN_ST_15X;
      end
      GAIN_ST_15X: begin
        gain_up = GAIN_ST_2X;
      end
      GAIN_ST_2X: begin
        gain_up = GAIN_ST_2X;
      end
      default: begin
        gain_up = GAIN_ST_1X;
      end
    endcase
  endfunction : gain_up

  // dwell before each climb
  function automatic int unsigned gain_limit(input gain_e g);
    case (g)
      GAIN_ST_1X: begin
        gain_limit = GAIN1_DELAY_CYC;
      end
      GAIN_ST_133X: begin
        gain_limit = GAIN2_DELAY_CYC;
      end
      GAIN_ST_15X: begin
        gain_limit = `GAIN_SKIP_CYC;
      end
      default: begin
        gain_limit = `GAIN_SKIP_CYC;
      end
    endcase
  endfunction : gain_limit

  function automatic logic [5:0] lit_mask(input logic en, input code_t code,
                                          input logic [5:0] near);
    logic [5:0] m;
    m = `CH_NONE;
    for (int i = 0; i < `NUM_CH; i++) begin
      m[i] = en && (code != `CODE_ZERO) && !near[i];
    end
    return m;
  endfunction : lit_mask

  function automatic logic [5:0] test_mask(input logic en, input logic [5:0] near);
    logic [5:0] m;
    m = `CH_NONE;
    for (int i = 0; i < `NUM_CH; i++) begin
      m[i] = en && near[i];
    end
    return m;
  endfunction : test_mask

  // ----------------------------------------
  // edge detect
  // ----------------------------------------
  logic rise;
  assign rise = pin_lvl && !st_reg.pin_d;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.pin_d = pin_lvl;

    // enable / program / shutdown sequencing
    case (st_reg.en_st)
      EN_ST_OFF: begin
        st_next.code = `CODE_ZERO;
        st_next.low_cnt = `CNT_ZERO;
        if (pin_lvl) begin
          st_next.en_st = EN_ST_ON;
        end
      end
      EN_ST_ON: begin
        if (rise) begin
          // wraps 15 -> 0, so fifteen pulses step one down
          st_next.code = st_reg.code + `CODE_ONE;
        end
        if (pin_lvl) begin
          st_next.low_cnt = `CNT_ZERO;
        end else if (cnt_hit(st_reg.low_cnt, OFF_LOW_CYC)) begin
          st_next.low_cnt = `CNT_ZERO;
          st_next.en_st = EN_ST_LOWWAIT;
        end else begin
          st_next.low_cnt = cnt_inc(st_reg.low_cnt);
        end
      end
      EN_ST_LOWWAIT: begin
        // shutdown accepted; channels go dark now, core winds down after delay
        st_next.code = `CODE_ZERO;
        if (cnt_hit(st_reg.low_cnt, PWRDN_DELAY_CYC)) begin
          st_next.low_cnt = `CNT_ZERO;
          st_next.en_st = EN_ST_PWRDN;
        end else begin
          st_next.low_cnt = cnt_inc(st_reg.low_cnt);
        end
      end
      EN_ST_PWRDN: begin
        st_next.code = `CODE_ZERO;
        st_next.low_cnt = `CNT_ZERO;
        if (!pin_lvl) begin
          st_next.en_st = EN_ST_OFF;
        end
      end
      default: begin
        st_next.en_st = EN_ST_OFF;
      end
    endcase

    // gain mode sequencing; only runs while enabled
    if (st_reg.en_st != EN_ST_ON || i_onex_sufficient) begin
      st_next.gain = GAIN_ST_1X;
      st_next.gain_cnt = `CNT_ZERO;
    end else if (!i_regulation_low) begin
      st_next.gain_cnt = `CNT_ZERO; // hold current mode, restart delay
    end else begin
      case (st_reg.gain)
        GAIN_ST_1X: begin
          if (cnt_hit(st_reg.gain_cnt, gain_limit(st_reg.gain))) begin
            st_next.gain = gain_up(st_reg.gain);
            st_next.gain_cnt = `CNT_ZERO;
          end else begin
            st_next.gain_cnt = cnt_inc(st_reg.gain_cnt);
          end
        end
        GAIN_ST_133X: begin
          if (cnt_hit(st_reg.gain_cnt, gain_limit(st_reg.gain))) begin
            st_next.gain = gain_up(st_reg.gain);
            st_next.gain_cnt = `CNT_ZERO;
          end else begin
            st_next.gain_cnt = cnt_inc(st_reg.gain_cnt);
          end
        end
        GAIN_ST_15X: begin
          // no delay given for this step; move on next cycle
          st_next.gain = gain_up(st_reg.gain);
          st_next.gain_cnt = `CNT_ZERO;
        end
        GAIN_ST_2X: begin
          st_next.gain_cnt = `CNT_ZERO;
        end
        default: begin
          st_next.gain = GAIN_ST_1X;
        end
      endcase
    end

    // under-voltage beats everything else
    if (i_supply_undervoltage) begin
      st_next.en_st = EN_ST_OFF;
      st_next.code = `CODE_ZERO;
      st_next.gain = GAIN_ST_1X;
      st_next.low_cnt = `CNT_ZERO;
      st_next.gain_cnt = `CNT_ZERO;
    end

    // ----------------------------------------
    // channel drive
    // ----------------------------------------
    st_next.enabled = is_on(st_next.en_st);
    st_next.ch_on = lit_mask(st_next.enabled, st_next.code,
                             i_cathode_near_output);
    st_next.test_on = test_mask(st_next.enabled, i_cathode_near_output);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs, straight from the state register
  // ----------------------------------------
  assign o_device_enabled = st_reg.enabled;
  assign o_current_code = st_reg.code;
  assign o_channel_on = st_reg.ch_on;
  assign o_test_current_on = st_reg.test_on;
  assign o_gain_mode = st_reg.gain;
endmodule : pulse_dimming_pump_mode_ctrl
`default_nettype wire

/* bench/pump_ctrl_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// port checker
// ----
module pump_ctrl_chk #(
  parameter int unsigned OFF_LOW_CYC = 40
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_enable_program,
  input wire logic i_supply_undervoltage,
  input wire logic i_onex_sufficient,
  input wire logic [5:0] i_cathode_near_output,
  input wire logic o_device_enabled,
  input wire logic [3:0] o_current_code,
  input wire logic [5:0] o_channel_on,
  input wire pump_ctrl_pkg::gain_e o_gain_mode
);
  import pump_ctrl_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // saturates, so a long off never wraps into a false short low
  logic [19:0] low_reg;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      low_reg <= 20'h00000;
    end else if (i_enable_program) begin
      low_reg <= 20'h00000;
    end else if (low_reg != 20'hFFFFF) begin
      low_reg <= low_reg + 20'h00001;
    end
  end
  a_zero_dark: assert property (o_current_code == 4'h0 |-> o_channel_on == 6'h00)
    else $error("channel lit at zero code");
  a_step_wrap: assert property ($changed(o_current_code) |-> o_current_code == 4'h0 ||
    o_current_code == $past(o_current_code) + 4'h1) else $error("code skipped");
  a_unused_off: assert property ($stable(i_cathode_near_output) |->
    (o_channel_on & i_cathode_near_output) == 6'h00) else $error("unused channel on");
  a_uv_clear: assert property (i_supply_undervoltage |=> o_current_code == 4'h0 &&
    !o_device_enabled) else $error("undervoltage ignored");
  a_off_dark: assert property (!o_device_enabled |-> o_channel_on == 6'h00)
    else $error("channel on while off");
  a_back_1x: assert property (i_onex_sufficient |=> o_gain_mode == GAIN_ST_1X)
    else $error("no return to 1x");
  a_gain_order: assert property ($changed(o_gain_mode) && o_gain_mode != GAIN_ST_1X |->
    o_gain_mode == ($past(o_gain_mode) == GAIN_ST_1X ? GAIN_ST_133X :
    $past(o_gain_mode) == GAIN_ST_133X ? GAIN_ST_15X : GAIN_ST_2X)) else $error("gain out of order");
  a_low_limit: assert property (low_reg >= 20'(OFF_LOW_CYC + 8) |-> !o_device_enabled)
    else $error("no shutdown on long low");
  a_short_hold: assert property (o_device_enabled && low_reg < 20'(OFF_LOW_CYC - 4) &&
    !i_supply_undervoltage |=> o_device_enabled) else $error("short low shut down");
endmodule : pump_ctrl_chk
bind pulse_dimming_pump_mode_ctrl pump_ctrl_chk #(.OFF_LOW_CYC(OFF_LOW_CYC)) u_pump_ctrl_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_enable_program(i_enable_program),
  .i_supply_undervoltage(i_supply_undervoltage), .i_onex_sufficient(i_onex_sufficient),
  .i_cathode_near_output(i_cathode_near_output), .o_device_enabled(o_device_enabled),
  .o_current_code(o_current_code), .o_channel_on(o_channel_on), .o_gain_mode(o_gain_mode));
`default_nettype wire

/* bench/pin_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// host on the enable/program pin
// ----
module pin_host (
  input wire logic i_sys_clk,
  output var logic o_pin
);
  initial o_pin = 1'b0;
  task automatic drive(input logic v, input int cyc);
    @(negedge i_sys_clk);
    o_pin = v;
    repeat (cyc - 1) @(negedge i_sys_clk);
  endtask : drive
  // 20-cycle phases: 0.2 us each, 400 ns period, the fastest allowed
  task automatic pulses(input int n);
    repeat (n) begin
      drive(1'b0, 20);
      drive(1'b1, 20);
    end
  endtask : pulses
endmodule : pin_host
`default_nettype wire

/* bench/pulse_dimming_pump_mode_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// bench
// ----
module pulse_dimming_pump_mode_ctrl_tb;
  import pump_ctrl_pkg::*;
  logic sys_clk, rst, pin, uv, reg_low, onex, en;
  logic [5:0] cath, chan_on, test_on;
  logic [3:0] code;
  gain_e gain;
  int errors = 0;
  int compares = 0;
  pin_host u_pin_host (.i_sys_clk(sys_clk), .o_pin(pin));
  pulse_dimming_pump_mode_ctrl #(.OFF_LOW_CYC(40), .PWRDN_DELAY_CYC(20), .GAIN1_DELAY_CYC(10),
    .GAIN2_DELAY_CYC(15)) u_pulse_dimming_pump_mode_ctrl (.i_sys_clk(sys_clk), .i_rst(rst),
    .i_enable_program(pin), .i_supply_undervoltage(uv), .i_regulation_low(reg_low),
    .i_onex_sufficient(onex), .i_cathode_near_output(cath), .o_device_enabled(en),
    .o_current_code(code), .o_channel_on(chan_on), .o_test_current_on(test_on),
    .o_gain_mode(gain));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string name, input logic [5:0] seen, input logic [5:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic t_steps;
    check("enabled", 6'(en), 6'h00);
    check("gain", 6'(gain), 6'(GAIN_ST_1X));
    u_pin_host.drive(1'b1, 20);
    check("enabled", 6'(en), 6'h01);
    check("chan", chan_on, 6'h00);
    u_pin_host.pulses(1);
    check("code", 6'(code), 6'h01);
    check("chan", chan_on, ~cath);
    check("test", test_on, cath);
    cath = 6'h00;
    cyc(2);
    check("chan", chan_on, 6'h3F);
    check("test", test_on, 6'h00);
    cath = 6'h21;
    cyc(2);
    u_pin_host.pulses(14);
    check("code", 6'(code), 6'h0F);
    u_pin_host.pulses(4);
    check("code", 6'(code), 6'h03);
    u_pin_host.pulses(15);
    check("code", 6'(code), 6'h02);
    $display("steps finished");
  endtask : t_steps
  task automatic t_gain;
    reg_low = 1'b1;
    cyc(7);
    check("gain", 6'(gain), 6'(GAIN_ST_1X));
    cyc(6);
    check("gain", 6'(gain), 6'(GAIN_ST_133X));
    cyc(9);
    check("gain", 6'(gain), 6'(GAIN_ST_133X));
    cyc(6);
    check("gain", 6'(gain), 6'(GAIN_ST_2X));
    reg_low = 1'b0;
    onex = 1'b1;
    cyc(2);
    check("gain", 6'(gain), 6'(GAIN_ST_1X));
    onex = 1'b0;
    uv = 1'b1;
    cyc(2);
    check("code", 6'(code), 6'h00);
    uv = 1'b0;
    cyc(8);
    check("enabled", 6'(en), 6'h01);
    $display("gain finished");
  endtask : t_gain
  task automatic t_shut;
    u_pin_host.drive(1'b0, 30);
    check("enabled", 6'(en), 6'h01);
    u_pin_host.drive(1'b1, 20);
    u_pin_host.drive(1'b0, 50);
    check("enabled", 6'(en), 6'h00);
    u_pin_host.drive(1'b1, 20);
    check("code", 6'(code), 6'h00);
    check("enabled", 6'(en), 6'h00);
    u_pin_host.drive(1'b0, 20);
    u_pin_host.drive(1'b1, 20);
    check("enabled", 6'(en), 6'h01);
    check("code", 6'(code), 6'h00);
    $display("shutdown finished");
  endtask : t_shut
  initial begin
    rst = 1'b1;
    uv = 1'b0;
    reg_low = 1'b0;
    onex = 1'b0;
    cath = 6'h21;
    cyc(12);
    rst = 1'b0;
    t_steps;
    t_gain;
    t_shut;
    stop_test;
  end
  initial begin
    #100000;
    errors++;
    stop_test;
  end
endmodule : pulse_dimming_pump_mode_ctrl_tb
`default_nettype wire
